// ---- rtl/hmirq_fan_chan.v ----
// one fan input channel: pin synchroniser, edge divider and level detect
`timescale 1ns/10ps
`default_nettype none

module hmirq_fan_chan (
  input  wire       ref_clk_i,
  input  wire       rst_b_i,
  input  wire       pin_i,
  input  wire       level_mode_i,
  input  wire [1:0] div_sel_i,
  input  wire       count_limit_i,
  output reg        tick_o,
  output reg        event_o
);

  reg       sync1_r;
  reg       sync2_r;
  reg       prev_r;
  reg [2:0] edge_cnt_r;
  wire [2:0] ratio_m1;
  wire       rise;
  wire       level_hit;

  // ==========================================================
  // synchroniser: second stage is the only reader of the first
  always @(posedge ref_clk_i) begin
    sync1_r <= pin_i;
    sync2_r <= sync1_r;
  end

  assign ratio_m1  = (3'h1 << div_sel_i) - 3'h1;
  assign rise      = sync2_r & ~prev_r;
  // low divisor bit set means a low level is the active one
  assign level_hit = div_sel_i[0] ? ~sync2_r : sync2_r;

  // ==========================================================
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prev_r     <= 1'b0;
      edge_cnt_r <= 3'h0;
      tick_o     <= 1'b0;
      event_o    <= 1'b0;
    end else begin
      prev_r  <= sync2_r;
      tick_o  <= 1'b0;
      if (!level_mode_i && rise) begin
        if (edge_cnt_r >= ratio_m1) begin
          edge_cnt_r <= 3'h0;
          tick_o     <= 1'b1;
        end else begin
          edge_cnt_r <= edge_cnt_r + 3'h1;
        end
      end
      event_o <= level_mode_i ? level_hit : count_limit_i;
    end
  end

endmodule // hmirq_fan_chan

`default_nettype wire

// ---- rtl/hmirq_map.vh ----
// register offsets, field positions and reset values of the monitor interrupt/config block
`ifndef HMIRQ_MAP_VH
`define HMIRQ_MAP_VH

// ============================================================
// register offsets on the serial bus
`define HMIRQ_OFS_STATUS      8'h02
`define HMIRQ_OFS_FAN_DIV     8'h05
`define HMIRQ_OFS_MASK2       8'h44

// ============================================================
// second interrupt mask fields
`define HMIRQ_M_HOT           0
`define HMIRQ_M_BTI           1
`define HMIRQ_M_FAN_A         2
`define HMIRQ_M_FAN_B         3
`define HMIRQ_M_INTR          4
`define HMIRQ_M_OS            5
`define HMIRQ_M_HOT_ONCE      6
`define HMIRQ_M_OS_ONCE       7
`define HMIRQ_MASK2_RST       8'h00

// ============================================================
// fan divisor / pin configuration fields
`define HMIRQ_F_A_LEVEL       0
`define HMIRQ_F_B_LEVEL       1
`define HMIRQ_F_A_DIV_LO      2
`define HMIRQ_F_A_DIV_HI      3
`define HMIRQ_F_B_DIV_LO      4
`define HMIRQ_F_B_DIV_HI      5
`define HMIRQ_F_OS_EN         6
`define HMIRQ_F_RST_EN        7
`define HMIRQ_FAN_DIV_UP_RST  4'h5

// ============================================================
// status bit positions (same order as the mask)
`define HMIRQ_S_HOT           0
`define HMIRQ_S_FAN_A         2
`define HMIRQ_S_FAN_B         3
`define HMIRQ_S_INTR          4
`define HMIRQ_S_OS            5
`define HMIRQ_STAT_W          6

`endif

// ---- rtl/hmirq_temp_src.v ----
// temperature interrupt source: default (per conversion) or one-time mode
`timescale 1ns/10ps
`default_nettype none

module hmirq_temp_src (
  input  wire ref_clk_i,
  input  wire rst_b_i,
  input  wire conv_done_i,
  input  wire above_i,
  input  wire below_i,
  input  wire one_time_i,
  output reg  set_o,
  output reg  active_o
);

  // ==========================================================
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      set_o    <= 1'b0;
      active_o <= 1'b0;
    end else begin
      set_o <= 1'b0;
      if (conv_done_i) begin
        if (one_time_i) begin
          // one event on the way up, one on the way down
          if (!active_o && above_i) begin
            active_o <= 1'b1;
            set_o    <= 1'b1;
          end else if (active_o && below_i) begin
            active_o <= 1'b0;
            set_o    <= 1'b1;
          end
        end else begin
          if (above_i)
            active_o <= 1'b1;
          else if (below_i)
            active_o <= 1'b0;
          // re-raise every conversion until under hysteresis
          if (above_i || (active_o && !below_i))
            set_o <= 1'b1;
        end
      end
    end
  end

endmodule // hmirq_temp_src

`default_nettype wire

// ---- rtl/hmirq_top.v ----
// monitor interrupt masking, temperature modes, fan/pin config and serial bus slave
`timescale 1ns/10ps
`default_nettype none
`include "hmirq_map.vh"

// Functional notes
// - a set mask bit for fan a, fan b, intrusion or overtemp keeps its status off the irq.
// - hot mode zero re-raises the hot status each conversion until below hysteresis.
// - hot mode one raises the hot status only once when the hot limit is crossed upward.
// - in one-time mode a second event is raised on falling below hysteresis, then none.
// - in one-time mode a status read clears the bit and it need not set again next time.
// - the overtemp mode bit selects default or one-time behaviour like the hot mode bit.
// - each fan mode bit picks level input when one and pulse counting when zero.
// - fan a divisor codes 00..11 divide pulses by 1, 2, 4 and 8.
// - fan b divisor codes 00..11 divide pulses by 1, 2, 4 and 8.
// - in level mode the low divisor bit one makes a low level active, zero a high level.
// - bit 6 set with bit 7 clear gives the shared pin its overtemp function.
// - bit 7 set gives the shared pin its reset function.
// - bits 6 and 7 both clear keep the shared pin inactive.
// - after power-on the upper nibble is 0101 and the lower nibble the voltage id levels.
module hmirq_top #(
  parameter [6:0] DEV_ADDR = 7'h2C
) (
  input  wire       ref_clk_i,
  input  wire       rst_b_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       fan_input_a_i,
  input  wire       fan_input_b_i,
  input  wire       intrusion_input_i,
  input  wire [3:0] voltage_id_inputs_i,
  input  wire       conv_done_i,
  input  wire       hot_above_i,
  input  wire       hot_below_i,
  input  wire       os_above_i,
  input  wire       os_below_i,
  input  wire       fan_limit_a_i,
  input  wire       fan_limit_b_i,
  input  wire       reset_request_i,
  output reg        irq_n_o,
  output reg        irq_oe_o,
  output reg        shared_reset_overtemp_pin_o,
  output reg        shared_reset_overtemp_pin_oe_o,
  output reg        fan_tick_a_o,
  output reg        fan_tick_b_o
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WBYTE = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RBYTE = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;
  localparam [2:0] ST_RNEXT = 3'h7;

  // synchroniser stages
  reg        scl_s1_r;
  reg        scl_s2_r;
  reg        scl_d_r;
  reg        sda_s1_r;
  reg        sda_s2_r;
  reg        sda_d_r;
  reg        intr_s1_r;
  reg        intr_s2_r;
  reg  [3:0] vid_s1_r;
  reg  [3:0] vid_s2_r;

  // registers
  reg  [7:0] mask2_r;
  reg  [7:0] fan_div_r;
  reg  [`HMIRQ_STAT_W-1:0] stat_r;
  reg  [`HMIRQ_STAT_W-1:0] stat_nxt;
  reg        por_load_r;

  // serial slave state
  reg  [2:0] state_r;
  reg  [2:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] ptr_r;
  reg        rw_r;
  reg        first_r;
  reg        stat_clr_r;

  reg  [7:0] rdata;
  wire [7:0] rx_byte;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire       hot_set;
  wire       hot_active;
  wire       os_set;
  wire       os_active;
  wire       fan_a_evt;
  wire       fan_b_evt;
  wire       fan_a_tick;
  wire       fan_b_tick;
  wire       irq_pending;

  // ==========================================================
  // pin synchronisers; edge logic reads only the second stage
  always @(posedge ref_clk_i) begin
    scl_s1_r  <= scl_i;
    scl_s2_r  <= scl_s1_r;
    sda_s1_r  <= sda_i;
    sda_s2_r  <= sda_s1_r;
    intr_s1_r <= intrusion_input_i;
    intr_s2_r <= intr_s1_r;
    vid_s1_r  <= voltage_id_inputs_i;
    vid_s2_r  <= vid_s1_r;
  end

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s2_r;
      sda_d_r <= sda_s2_r;
    end
  end

  assign scl_rise   = scl_s2_r & ~scl_d_r;
  assign scl_fall   = ~scl_s2_r & scl_d_r;
  assign start_cond = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
  assign stop_cond  = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;
  assign rx_byte    = {shift_r[6:0], sda_s2_r};

  // ==========================================================
  // interrupt sources
  hmirq_fan_chan u_fan_a (
    .ref_clk_i     (ref_clk_i),
    .rst_b_i       (rst_b_i),
    .pin_i         (fan_input_a_i),
    .level_mode_i  (fan_div_r[`HMIRQ_F_A_LEVEL]),
    .div_sel_i     (fan_div_r[`HMIRQ_F_A_DIV_HI:`HMIRQ_F_A_DIV_LO]),
    .count_limit_i (fan_limit_a_i),
    .tick_o        (fan_a_tick),
    .event_o       (fan_a_evt)
  );

  // fan b polarity comes from its own low divisor bit through the shared channel
  hmirq_fan_chan u_fan_b (
    .ref_clk_i     (ref_clk_i),
    .rst_b_i       (rst_b_i),
    .pin_i         (fan_input_b_i),
    .level_mode_i  (fan_div_r[`HMIRQ_F_B_LEVEL]),
    .div_sel_i     (fan_div_r[`HMIRQ_F_B_DIV_HI:`HMIRQ_F_B_DIV_LO]),
    .count_limit_i (fan_limit_b_i),
    .tick_o        (fan_b_tick),
    .event_o       (fan_b_evt)
  );

  hmirq_temp_src u_hot (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .conv_done_i (conv_done_i),
    .above_i     (hot_above_i),
    .below_i     (hot_below_i),
    .one_time_i  (mask2_r[`HMIRQ_M_HOT_ONCE]),
    .set_o       (hot_set),
    .active_o    (hot_active)
  );

  hmirq_temp_src u_os (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .conv_done_i (conv_done_i),
    .above_i     (os_above_i),
    .below_i     (os_below_i),
    .one_time_i  (mask2_r[`HMIRQ_M_OS_ONCE]),
    .set_o       (os_set),
    .active_o    (os_active)
  );

  // ==========================================================
  // sticky status: a set in the clearing cycle survives the clear
  always @* begin
    stat_nxt = stat_clr_r ? {`HMIRQ_STAT_W{1'b0}} : stat_r;
    if (hot_set)
      stat_nxt[`HMIRQ_S_HOT] = 1'b1;
    if (fan_a_evt)
      stat_nxt[`HMIRQ_S_FAN_A] = 1'b1;
    if (fan_b_evt)
      stat_nxt[`HMIRQ_S_FAN_B] = 1'b1;
    if (intr_s2_r)
      stat_nxt[`HMIRQ_S_INTR] = 1'b1;
    if (os_set)
      stat_nxt[`HMIRQ_S_OS] = 1'b1;
  end

  assign irq_pending = |(stat_r & ~mask2_r[`HMIRQ_STAT_W-1:0]);

  always @* begin
    case (ptr_r)
      `HMIRQ_OFS_STATUS:  rdata = {2'h0, stat_r};
      `HMIRQ_OFS_FAN_DIV: rdata = fan_div_r;
      `HMIRQ_OFS_MASK2:   rdata = mask2_r;
      default:            rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // registers, power-on load and pin drivers
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      stat_r                         <= {`HMIRQ_STAT_W{1'b0}};
      mask2_r                        <= `HMIRQ_MASK2_RST;
      fan_div_r                      <= {`HMIRQ_FAN_DIV_UP_RST, 4'h0};
      por_load_r                     <= 1'b1;
      irq_n_o                        <= 1'b0;
      irq_oe_o                       <= 1'b0;
      shared_reset_overtemp_pin_o    <= 1'b0;
      shared_reset_overtemp_pin_oe_o <= 1'b0;
      fan_tick_a_o                   <= 1'b0;
      fan_tick_b_o                   <= 1'b0;
    end else begin
      stat_r       <= stat_nxt;
      por_load_r   <= 1'b0;
      irq_n_o      <= 1'b0;
      irq_oe_o     <= irq_pending;
      fan_tick_a_o <= fan_a_tick;
      fan_tick_b_o <= fan_b_tick;
      // strap capture happens the cycle after reset release
      if (por_load_r)
        fan_div_r <= {`HMIRQ_FAN_DIV_UP_RST, vid_s2_r};
      if (state_r == ST_WBYTE && scl_rise && bit_cnt_r == 3'h7 && !first_r) begin
        if (ptr_r == `HMIRQ_OFS_MASK2)
          mask2_r <= rx_byte;
        if (ptr_r == `HMIRQ_OFS_FAN_DIV)
          fan_div_r <= rx_byte;
      end
      shared_reset_overtemp_pin_o <= 1'b0;
      if (fan_div_r[`HMIRQ_F_RST_EN])
        shared_reset_overtemp_pin_oe_o <= reset_request_i;
      else if (fan_div_r[`HMIRQ_F_OS_EN])
        shared_reset_overtemp_pin_oe_o <= os_active;
      else
        shared_reset_overtemp_pin_oe_o <= 1'b0;
    end
  end

  // ==========================================================
  // serial bus slave: sample on clock rise, drive on clock fall
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 3'h0;
      shift_r    <= 8'h00;
      ptr_r      <= 8'h00;
      rw_r       <= 1'b0;
      first_r    <= 1'b0;
      stat_clr_r <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
    end else begin
      stat_clr_r <= 1'b0;
      sda_o      <= 1'b0;
      if (start_cond) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 3'h0;
        first_r   <= 1'b1;
        sda_oe_o  <= 1'b0;
      end else if (stop_cond) begin
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_WBYTE, ST_RBYTE: begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              if (state_r == ST_ADDR) begin
                rw_r    <= sda_s2_r;
                state_r <= (shift_r[6:0] == DEV_ADDR) ? ST_AACK : ST_IDLE;
              end else if (state_r == ST_WBYTE) begin
                if (first_r)
                  ptr_r <= rx_byte;
                first_r <= 1'b0;
                state_r <= ST_WACK;
              end else begin
                state_r <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            // a high level is the master's not-acknowledge
            state_r <= sda_s2_r ? ST_IDLE : ST_RNEXT;
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_AACK, ST_WACK: begin
            if (!sda_oe_o) begin
              sda_oe_o <= 1'b1;
            end else if (state_r == ST_AACK && rw_r) begin
              shift_r    <= rdata;
              sda_oe_o   <= ~rdata[7];
              bit_cnt_r  <= 3'h0;
              stat_clr_r <= (ptr_r == `HMIRQ_OFS_STATUS);
              state_r    <= ST_RBYTE;
            end else begin
              sda_oe_o  <= 1'b0;
              bit_cnt_r <= 3'h0;
              state_r   <= ST_WBYTE;
            end
          end
          ST_RNEXT: begin
            shift_r    <= rdata;
            sda_oe_o   <= ~rdata[7];
            bit_cnt_r  <= 3'h0;
            stat_clr_r <= (ptr_r == `HMIRQ_OFS_STATUS);
            state_r    <= ST_RBYTE;
          end
          ST_RBYTE: begin
            sda_oe_o <= ~shift_r[7];
          end
          ST_RACK: begin
            sda_oe_o <= 1'b0;
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // hmirq_top

`default_nettype wire

// ---- verification/hmirq_host_model.sv ----
// serial bus host model: drives the bus clock and pulls the data line
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host
module mimfpc_host #(
  parameter logic [6:0] DEV = 7'h2C
) (
  output var logic scl_o,
  output var logic pull_o,
  input  wire logic sda_i
);
  localparam int Q = 200;
  logic [6:0] dev = DEV;
  // clock idles high between frames, data line left to its pull-up
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic bt(input logic b, output logic r);
    pull_o = ~b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic st;
    pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q pull_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic sp;
    pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q pull_o = 1'b0;
    #Q;
  endtask
  task automatic tx(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    st();
    tx({dev, 1'b0}, ok);
    tx(p, ok);
    tx(d, ok);
    sp();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    st();
    tx({dev, 1'b0}, ok);
    tx(p, ok);
    st();
    tx({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(1'b1, r);
    sp();
  endtask
endmodule // mimfpc_host
`default_nettype wire

// ---- verification/hmirq_top_asserts.sv ----
// port assertions for the monitor interrupt and pin configuration block
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// checker
module mimfpc_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic fan_input_a_i,
  input wire logic fan_input_b_i,
  input wire logic os_above_i,
  input wire logic reset_request_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_n_o,
  input wire logic shared_reset_overtemp_pin_o,
  input wire logic shared_reset_overtemp_pin_oe_o,
  input wire logic fan_tick_a_o,
  input wire logic fan_tick_b_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_od_low:
    assert property (!sda_o && !irq_n_o && !shared_reset_overtemp_pin_o)
    else $error("open-drain level not low");
  a_tick_a_once:
    assert property (fan_tick_a_o |=> !fan_tick_a_o) else $error("fan a tick too long");
  a_tick_b_once:
    assert property (fan_tick_b_o |=> !fan_tick_b_o) else $error("fan b tick too long");
  a_tick_a_cause:
    assert property (fan_tick_a_o |-> $past(fan_input_a_i, 2)) else $error("fan a tick unprompted");
  a_tick_b_cause:
    assert property (fan_tick_b_o |-> $past(fan_input_b_i, 2)) else $error("fan b tick unprompted");
  // data may only move while the bus clock is low, else it reads as start or stop
  a_data_stable:
    assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved with clock high");
  a_ack_hold:
    assert property ($rose(sda_oe_o) |-> sda_oe_o [*4]) else $error("data pull too short");
  a_pin_cause:
    assert property ($rose(shared_reset_overtemp_pin_oe_o)
      |-> $past(reset_request_i) || $past(os_above_i)) else $error("shared pin unprompted");
endmodule // mimfpc_asserts

bind hmirq_top mimfpc_asserts u_chk (
  .ref_clk_i, .rst_b_i, .scl_i, .fan_input_a_i, .fan_input_b_i, .os_above_i,
  .reset_request_i, .sda_o, .sda_oe_o, .irq_n_o, .shared_reset_overtemp_pin_o,
  .shared_reset_overtemp_pin_oe_o, .fan_tick_a_o, .fan_tick_b_o
);
`default_nettype wire

// ---- verification/monitor_irq_mask_fan_pin_config_tb.sv ----
// self-checking bench for the monitor interrupt and pin configuration block
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench
module monitor_irq_mask_fan_pin_config_tb;
  localparam logic [4:0] PAT = 5'b10011;
  localparam logic [4:0] ALT = 5'b10101;
  localparam logic [7:0] CFG [5] = '{8'h1C, 8'h5C, 8'h9C, 8'h9C, 8'hDC};
  localparam logic [4:0] RRQ = 5'b11001;
  localparam logic [4:0] PEX = 5'b11010;
  logic       ref_clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       fa = 1'b0, fb = 1'b0, intr = 1'b0, conv = 1'b0, rr = 1'b0;
  logic       hab = 1'b0, hbl = 1'b1, oab = 1'b0, obl = 1'b1, la = 1'b0, lb = 1'b0;
  logic [3:0] voltage_id_inputs = 4'hC;
  logic [7:0] v, hit;
  logic       ok;
  int         num_errors = 0, tests_run = 0, cyc = 0, n_a = 0, n_b = 0, a0, b0;
  wire        scl, pull, sda_oe, irq_oe, pin_oe, tk_a, tk_b;
  wire        sda = ~(sda_oe | pull);

  initial forever #50 ref_clk_i = ~ref_clk_i;

  hmirq_top DUT (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .fan_input_a_i(fa), .fan_input_b_i(fb), .intrusion_input_i(intr),
    .voltage_id_inputs_i(voltage_id_inputs), .conv_done_i(conv), .hot_above_i(hab), .hot_below_i(hbl),
    .os_above_i(oab), .os_below_i(obl), .fan_limit_a_i(la), .fan_limit_b_i(lb),
    .reset_request_i(rr), .irq_n_o(), .irq_oe_o(irq_oe), .shared_reset_overtemp_pin_o(),
    .shared_reset_overtemp_pin_oe_o(pin_oe), .fan_tick_a_o(tk_a), .fan_tick_b_o(tk_b)
  );
  mimfpc_host host (.scl_o(scl), .pull_o(pull), .sda_i(sda));

  // ==========================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    @(negedge ref_clk_i);
    host.wr(p, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    @(negedge ref_clk_i);
    host.rd(p, v, ok);
    check(v, e);
  endtask
  task automatic conv_pulse;
    @(negedge ref_clk_i) conv = 1'b1;
    @(negedge ref_clk_i) conv = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic temp(input int t, input logic a);
    if (t == 0) begin
      hab = a;
      hbl = ~a;
    end else begin
      oab = a;
      obl = ~a;
    end
    conv_pulse();
  endtask
  task automatic src(input int k, input logic a);
    case (k)
      2: la = a;
      3: lb = a;
      4: intr = a;
      default: temp(1, a);
    endcase
  endtask
  task automatic irq_is(input logic e);
    repeat (4) @(negedge ref_clk_i);
    check({7'h00, irq_oe}, {7'h00, e});
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (tk_a === 1'b1) n_a <= n_a + 1;
    if (tk_b === 1'b1) n_b <= n_b + 1;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rreg(8'h05, 8'h5C);
    rreg(8'h44, 8'h00);
    for (int k = 2; k < 6; k++) begin
      wreg(8'h44, 8'h01 << k);
      src(k, 1'b1);
      irq_is(1'b0);
      wreg(8'h44, 8'h00);
      irq_is(1'b1);
      src(k, 1'b0);
      rreg(8'h02, 8'h01 << k);
      irq_is(1'b0);
    end
    for (int t = 0; t < 2; t++) begin
      hit = t ? 8'h20 : 8'h01;
      for (int m = 0; m < 2; m++) begin
        wreg(8'h44, {m[0] & t[0], m[0] & ~t[0], 6'h00});
        // both sources below hysteresis, so a hot source left active cannot leak into os reads
        temp(0, 1'b0);
        temp(1, 1'b0);
        host.rd(8'h02, v, ok);
        for (int s = 0; s < 5; s++) begin
          temp(t, PAT[s]);
          rreg(8'h02, (m ? ALT[s] : PAT[s]) ? hit : 8'h00);
        end
      end
    end
    wreg(8'h44, 8'h00);
    temp(1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rr = RRQ[i];
      wreg(8'h05, CFG[i]);
      rreg(8'h05, CFG[i]);
      check({7'h00, pin_oe}, {7'h00, PEX[i]});
    end
    rr = 1'b0;
    temp(1, 1'b0);
    for (int d = 0; d < 4; d++) begin
      wreg(8'h05, {2'b00, d[1:0], d[1:0], 2'b00});
      a0 = n_a;
      b0 = n_b;
      repeat (16) begin
        fa = 1'b1;
        fb = 1'b1;
        repeat (8) @(negedge ref_clk_i);
        fa = 1'b0;
        fb = 1'b0;
        repeat (8) @(negedge ref_clk_i);
      end
      check(8'(n_a - a0), 8'(16 >> d));
      check(8'(n_b - b0), 8'(16 >> d));
    end
    for (int p = 0; p < 2; p++) begin
      wreg(8'h05, {3'b000, p[0], 1'b0, p[0], 2'b11});
      fa = p[0];
      fb = p[0];
      host.rd(8'h02, v, ok);
      rreg(8'h02, 8'h00);
      fa = ~p[0];
      fb = ~p[0];
      rreg(8'h02, 8'h0C);
    end
    fa = 1'b0;
    fb = 1'b0;
    // a foreign device address must be ignored and left unacknowledged
    host.dev = 7'h2D;
    @(negedge ref_clk_i);
    host.wr(8'h44, 8'h55, ok);
    check({7'h00, ok}, 8'h00);
    host.dev = 7'h2C;
    rreg(8'h44, 8'h00);
    wreg(8'h10, 8'hAA);
    rreg(8'h10, 8'h00);
    wreg(8'h44, 8'h3C);
    rreg(8'h44, 8'h3C);
    test_done();
  end
endmodule // monitor_irq_mask_fan_pin_config_tb
`default_nettype wire
